// ==== hw/ncs_map.svh ====
`ifndef NCS_MAP_SVH
`define NCS_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define NCS_A_NCO_LO 10'h220
`define NCS_A_NCO_HI 10'h25f
`define NCS_A_NCO_PH 10'h240
`define NCS_A_REV 10'h297
`define NCS_A_EN 10'h2b0
`define NCS_A_CFG 10'h2b1
`define NCS_A_STAT0 10'h2b2
`define NCS_A_STAT1 10'h2b3
`define NCS_A_STAT2 10'h2b4
`define NCS_A_TAD0 10'h2b5
`define NCS_A_TAD1 10'h2b6
`define NCS_A_TAD2 10'h2b7
`define NCS_A_RAMP 10'h2b8
`define NCS_A_GRP_HI 10'h2bf
`define NCS_A_IRQ_STAT 10'h2c0
`define NCS_A_IRQ_CLR 10'h2c1
`define NCS_A_IRQ_EN 10'h2c2
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define NCS_CFG_RST 8'h05
`define NCS_FREQ_RST 32'hc0000000
`define NCS_CFG_AVG_LSB 2
`define NCS_CFG_ACC_LSB 0
`define NCS_DONE_BIT 17
`define NCS_IRQ_DONE 0
`define NCS_IRQ_FAIL 1
`define NCS_IRQ_LIVE 2
// ----------------------------------------
// calibration counts
// ----------------------------------------
`define NCS_AVG_0 9'h004
`define NCS_AVG_1 9'h010
`define NCS_AVG_2 9'h040
`define NCS_AVG_3 9'h100
`define NCS_PER_0 15'd85
`define NCS_PER_1 15'd1100
`define NCS_PER_2 15'd5200
`define NCS_PER_3 15'd21580
`endif

// ==== hw/ncs_pkg.sv ====
package ncs_pkg;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE, CAL_FAIL} ncs_cal_st_t;
   typedef logic [31:0] ncs_word_t;
endpackage : ncs_pkg

// ==== hw/ncs_mem_if.sv ====
`timescale 1ns/1ps
interface ncs_mem_if #(parameter int AW = 6);
   logic sw_wr;
   logic [AW-1:0] sw_addr;
   logic [7:0] sw_wdata;
   logic [7:0] sw_rdata;
   logic [AW-3:0] dp_addr;
   ncs_pkg::ncs_word_t dp_rdata;
   modport ctrl (output sw_wr, sw_addr, sw_wdata, dp_addr, input sw_rdata, dp_rdata);
   modport mem (input sw_wr, sw_addr, sw_wdata, dp_addr, output sw_rdata, dp_rdata);
endinterface : ncs_mem_if

// ==== hw/ncs_word_mem.sv ====
`timescale 1ns/1ps
`include "ncs_map.svh"
module ncs_word_mem #(
   parameter int AW = 6
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // access ports
   ncs_mem_if.mem port_if
);
   import ncs_pkg::*;
   localparam int NW = 2 ** (AW - 2);

   typedef struct packed {
      logic [NW-1:0][3:0][7:0] words;
      logic [7:0] sw_rdata;
      ncs_word_t dp_rdata;
   } ncs_mem_state_t;

   ncs_mem_state_t s_reg;
   ncs_mem_state_t s_next;

   // ----------------------------------------
   // byte write, registered reads
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      // phase entries sit in the upper half and keep only two bytes
      if (port_if.sw_wr && !(port_if.sw_addr[AW-1] && port_if.sw_addr[1])) begin
         s_next.words[port_if.sw_addr[AW-1:2]][port_if.sw_addr[1:0]] = port_if.sw_wdata;
      end
      s_next.sw_rdata = s_reg.words[port_if.sw_addr[AW-1:2]][port_if.sw_addr[1:0]];
      s_next.dp_rdata = s_reg.words[port_if.dp_addr];
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_reg <= '0;
         for (int i = 0; i < NW / 2; i++) begin
            s_reg.words[i] <= `NCS_FREQ_RST;
         end
      end else begin
         s_reg <= s_next;
      end
   end

   assign port_if.sw_rdata = s_reg.sw_rdata;
   assign port_if.dp_rdata = s_reg.dp_rdata;

   mem_write_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (port_if.sw_wr && !port_if.sw_addr[AW-1]) |=>
      s_reg.words[$past(port_if.sw_addr[AW-1:2])][$past(port_if.sw_addr[1:0])]
      == $past(port_if.sw_wdata))
      else $error("word byte not stored");
endmodule : ncs_word_mem

// ==== hw/ncs_regs.sv ====
`timescale 1ns/1ps
`include "ncs_map.svh"
module ncs_regs #(
   parameter int PRESETS = 4,
   parameter logic [4:0] REV_CODE = 5'h0b // arbitrary value
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // register port
   input wire logic [9:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // pins
   input wire logic sysref_in,
   input wire logic link_running_in,
   input wire logic [$clog2(PRESETS)-1:0] chan_a_preset_in,
   input wire logic [$clog2(PRESETS)-1:0] chan_b_preset_in,
   // calibration engine
   input wire logic [16:0] cal_measure_in,
   // outputs
   output logic [16:0] tad_delay_out,
   output logic [7:0] ramp_ctrl_out,
   output ncs_pkg::ncs_word_t chan_a_phase_out,
   output ncs_pkg::ncs_word_t chan_b_phase_out,
   output logic irq_out
);
   import ncs_pkg::*;
   localparam int PW = $clog2(PRESETS);
   localparam int AW = PW + 4;

   typedef struct packed {
      logic [1:0] sref_sync;
      logic [1:0] link_sync;
      logic [1:0][PW-1:0] psel_a_sync;
      logic [1:0][PW-1:0] psel_b_sync;
      logic sref_prev;
      logic link_prev;
      logic en;
      logic [7:0] cfg;
      logic [23:0] tad_man;
      logic [7:0] ramp;
      logic [16:0] cal_tad;
      ncs_cal_st_t st;
      logic [14:0] per_cnt;
      logic [8:0] avg_cnt;
      logic [2:0] irq_stat;
      logic [2:0] irq_en;
      logic [1:0] fetch;
      ncs_word_t freq_a;
      ncs_word_t freq_b;
      logic [15:0] ph_a;
      logic [15:0] ph_b;
      ncs_word_t acc_a;
      ncs_word_t acc_b;
      logic mem_rd;
      logic [7:0] rdata;
      logic [16:0] tad_o;
      ncs_word_t out_a;
      ncs_word_t out_b;
      logic irq;
   } ncs_state_t;

   ncs_state_t s_reg;
   ncs_state_t s_next;
   ncs_mem_if #(.AW(AW)) mem_if ();

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic [8:0] avg_target(input logic [1:0] code);
      if (code == 2'd0) avg_target = `NCS_AVG_0;
      else if (code == 2'd1) avg_target = `NCS_AVG_1;
      else if (code == 2'd2) avg_target = `NCS_AVG_2;
      else avg_target = `NCS_AVG_3;
   endfunction : avg_target

   function automatic logic [14:0] per_limit(input logic [1:0] code);
      if (code == 2'd0) per_limit = `NCS_PER_0;
      else if (code == 2'd1) per_limit = `NCS_PER_1;
      else if (code == 2'd2) per_limit = `NCS_PER_2;
      else per_limit = `NCS_PER_3;
   endfunction : per_limit

   function automatic logic in_nco(input logic [9:0] a);
      in_nco = (a >= `NCS_A_NCO_LO) && (a <= `NCS_A_NCO_HI);
   endfunction : in_nco

   logic [9:0] nco_off;
   logic [1:0] avg_code;
   logic [1:0] acc_code;
   logic sref_rise;
   logic link_rise;
   logic launch;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic [AW-3:0] fetch_idx;

   assign nco_off = reg_addr_in - `NCS_A_NCO_LO;
   assign avg_code = s_reg.cfg[`NCS_CFG_AVG_LSB +: 2];
   assign acc_code = s_reg.cfg[`NCS_CFG_ACC_LSB +: 2];
   assign sref_rise = s_reg.sref_sync[1] && !s_reg.sref_prev;
   assign link_rise = s_reg.link_sync[1] && !s_reg.link_prev;
   assign launch = reg_wr_in && (reg_addr_in == `NCS_A_EN) && reg_wdata_in[0] && !s_reg.en;

   // ----------------------------------------
   // word memory
   // ----------------------------------------
   always_comb begin
      fetch_idx = '0;
      case (s_reg.fetch)
         2'd0: fetch_idx = {2'b00, s_reg.psel_a_sync[1]};
         2'd1: fetch_idx = {2'b10, s_reg.psel_a_sync[1]};
         2'd2: fetch_idx = {2'b01, s_reg.psel_b_sync[1]};
         default: fetch_idx = {2'b11, s_reg.psel_b_sync[1]};
      endcase
   end

   assign mem_if.sw_wr = reg_wr_in && in_nco(reg_addr_in);
   assign mem_if.sw_addr = nco_off[AW-1:0];
   assign mem_if.sw_wdata = reg_wdata_in;
   assign mem_if.dp_addr = fetch_idx;

   ncs_word_mem #(.AW(AW)) u_mem (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .port_if(mem_if)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      irq_set = '0;
      irq_clr = '0;
      s_next.sref_sync = {s_reg.sref_sync[0], sysref_in};
      s_next.link_sync = {s_reg.link_sync[0], link_running_in};
      s_next.psel_a_sync = {s_reg.psel_a_sync[0], chan_a_preset_in};
      s_next.psel_b_sync = {s_reg.psel_b_sync[0], chan_b_preset_in};
      s_next.sref_prev = s_reg.sref_sync[1];
      s_next.link_prev = s_reg.link_sync[1];
      // register writes
      if (reg_wr_in) begin
         if (reg_addr_in == `NCS_A_EN) begin
            s_next.en = reg_wdata_in[0];
         end else if (reg_addr_in == `NCS_A_CFG) begin
            s_next.cfg = {4'h0, reg_wdata_in[3:0]};
         end else if (reg_addr_in == `NCS_A_TAD0) begin
            s_next.tad_man[7:0] = reg_wdata_in;
         end else if (reg_addr_in == `NCS_A_TAD1) begin
            s_next.tad_man[15:8] = reg_wdata_in;
         end else if (reg_addr_in == `NCS_A_TAD2) begin
            s_next.tad_man[23:16] = reg_wdata_in;
         end else if (reg_addr_in == `NCS_A_RAMP) begin
            s_next.ramp = reg_wdata_in;
         end else if (reg_addr_in == `NCS_A_IRQ_CLR) begin
            irq_clr = reg_wdata_in[2:0];
         end else if (reg_addr_in == `NCS_A_IRQ_EN) begin
            s_next.irq_en = reg_wdata_in[2:0];
         end else if (in_nco(reg_addr_in) && !nco_off[AW-1] && s_reg.link_sync[1]) begin
            irq_set[`NCS_IRQ_LIVE] = 1'b1;
         end
      end
      // calibration sequencer
      case (s_reg.st)
         CAL_IDLE: begin
            if (launch) begin
               s_next.st = CAL_RUN;
               s_next.per_cnt = '0;
               s_next.avg_cnt = '0;
            end
         end
         CAL_RUN: begin
            s_next.per_cnt = s_reg.per_cnt + 15'd1;
            if (s_reg.per_cnt > per_limit(acc_code)) begin
               s_next.st = CAL_FAIL;
               irq_set[`NCS_IRQ_FAIL] = 1'b1;
            end else if (sref_rise) begin
               s_next.per_cnt = '0;
               s_next.avg_cnt = s_reg.avg_cnt + 9'd1;
               if (s_reg.avg_cnt + 9'd1 == avg_target(avg_code)) begin
                  s_next.st = CAL_DONE;
                  s_next.cal_tad = cal_measure_in;
                  irq_set[`NCS_IRQ_DONE] = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      if (reg_wr_in && (reg_addr_in == `NCS_A_EN) && !reg_wdata_in[0]) begin
         s_next.st = CAL_IDLE;
      end
      // sticky events, set beats clear
      s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;
      s_next.irq = |(s_next.irq_stat & s_next.irq_en);
      // delay select
      s_next.tad_o = s_reg.en ? s_reg.cal_tad : s_reg.tad_man[16:0];
      // oscillator word fetch, round robin
      s_next.fetch = s_reg.fetch + 2'd1;
      case (s_reg.fetch)
         2'd1: s_next.freq_a = mem_if.dp_rdata;
         2'd2: s_next.ph_a = mem_if.dp_rdata[15:0];
         2'd3: s_next.freq_b = mem_if.dp_rdata;
         default: s_next.ph_b = mem_if.dp_rdata[15:0];
      endcase
      // accumulators, realigned when the link starts
      if (link_rise) begin
         s_next.acc_a = '0;
         s_next.acc_b = '0;
      end else begin
         s_next.acc_a = s_reg.acc_a + s_reg.freq_a;
         s_next.acc_b = s_reg.acc_b + s_reg.freq_b;
      end
      s_next.out_a = s_reg.acc_a + {s_reg.ph_a, 16'h0000};
      s_next.out_b = s_reg.acc_b + {s_reg.ph_b, 16'h0000};
      // register reads
      s_next.mem_rd = reg_rd_in && in_nco(reg_addr_in);
      s_next.rdata = 8'h00;
      if (reg_rd_in) begin
         if (reg_addr_in == `NCS_A_REV) begin
            s_next.rdata = {3'b000, REV_CODE};
         end else if (reg_addr_in == `NCS_A_EN) begin
            s_next.rdata = {7'h00, s_reg.en};
         end else if (reg_addr_in == `NCS_A_CFG) begin
            s_next.rdata = s_reg.cfg;
         end else if (reg_addr_in == `NCS_A_STAT0) begin
            s_next.rdata = s_reg.cal_tad[7:0];
         end else if (reg_addr_in == `NCS_A_STAT1) begin
            s_next.rdata = s_reg.cal_tad[15:8];
         end else if (reg_addr_in == `NCS_A_STAT2) begin
            s_next.rdata = {6'h00, s_reg.en && (s_reg.st == CAL_DONE), s_reg.cal_tad[16]};
         end else if (reg_addr_in == `NCS_A_TAD0) begin
            s_next.rdata = s_reg.tad_man[7:0];
         end else if (reg_addr_in == `NCS_A_TAD1) begin
            s_next.rdata = s_reg.tad_man[15:8];
         end else if (reg_addr_in == `NCS_A_TAD2) begin
            s_next.rdata = s_reg.tad_man[23:16];
         end else if (reg_addr_in == `NCS_A_RAMP) begin
            s_next.rdata = s_reg.ramp;
         end else if (reg_addr_in == `NCS_A_IRQ_STAT) begin
            s_next.rdata = {5'h00, s_reg.irq_stat};
         end else if (reg_addr_in == `NCS_A_IRQ_EN) begin
            s_next.rdata = {5'h00, s_reg.irq_en};
         end else begin
            s_next.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_reg <= '0;
         s_reg.cfg <= `NCS_CFG_RST;
         s_reg.st <= CAL_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata_out = s_reg.mem_rd ? mem_if.sw_rdata : s_reg.rdata;
   assign tad_delay_out = s_reg.tad_o;
   assign ramp_ctrl_out = s_reg.ramp;
   assign chan_a_phase_out = s_reg.out_a;
   assign chan_b_phase_out = s_reg.out_b;
   assign irq_out = s_reg.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   tad_manual_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      !s_reg.en |=> tad_delay_out == $past(s_reg.tad_man[16:0]))
      else $error("manual delay not on output");

   tad_auto_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      s_reg.en |=> tad_delay_out == $past(s_reg.cal_tad))
      else $error("calibrated delay not on output");

   cal_launch_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (launch && s_reg.st == CAL_IDLE) |=> s_reg.st == CAL_RUN && s_reg.avg_cnt == 9'd0)
      else $error("rising enable did not start");

   no_restart_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (s_reg.en && s_reg.st == CAL_DONE && reg_wr_in && reg_addr_in == `NCS_A_EN
      && reg_wdata_in[0]) |=> s_reg.st == CAL_DONE)
      else $error("held enable restarted calibration");

   done_gate_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (reg_rd_in && reg_addr_in == `NCS_A_STAT2) |=>
      reg_rdata_out[1] == ($past(s_reg.en) && $past(s_reg.st) == CAL_DONE))
      else $error("done bit wrong");

   avg_done_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (s_reg.st == CAL_DONE && $past(s_reg.st) == CAL_RUN) |->
      s_reg.avg_cnt == avg_target($past(avg_code)))
      else $error("wrong average count at done");

   period_fail_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (s_reg.st == CAL_RUN && s_reg.per_cnt > per_limit(acc_code)
      && !(reg_wr_in && reg_addr_in == `NCS_A_EN)) |=> s_reg.st == CAL_FAIL)
      else $error("long period did not fail");

   acc_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      !link_rise |=> s_reg.acc_a == 32'($past(s_reg.acc_a) + $past(s_reg.freq_a)))
      else $error("accumulator step wrong");

   phase_add_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      ##1 chan_b_phase_out == 32'($past(s_reg.acc_b) + {$past(s_reg.ph_b), 16'h0000}))
      else $error("phase offset not applied");

   rev_read_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (reg_rd_in && reg_addr_in == `NCS_A_REV) |=> reg_rdata_out == {3'b000, REV_CODE})
      else $error("revision read wrong");

   reserved_read_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (reg_rd_in && reg_addr_in > `NCS_A_RAMP && reg_addr_in <= `NCS_A_GRP_HI)
      |=> reg_rdata_out == 8'h00)
      else $error("reserved byte not zero");

   live_flag_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (reg_wr_in && in_nco(reg_addr_in) && !nco_off[AW-1] && s_reg.link_sync[1])
      |=> s_reg.irq_stat[`NCS_IRQ_LIVE])
      else $error("live rewrite not flagged");
endmodule : ncs_regs

// ==== verif/tb_nco_word_and_sysref_cal_regs.sv ====
`timescale 1ns/1ps
`include "ncs_map.svh"
module tb_nco_word_and_sysref_cal_regs;
   import ncs_pkg::*;
   localparam logic [4:0] REV = 5'h13; // arbitrary value
   logic clk_sys_in;
   logic reset_n_in;
   logic [9:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [7:0] reg_rdata_out;
   logic sysref_in;
   logic link_running_in;
   logic [1:0] chan_a_preset_in;
   logic [1:0] chan_b_preset_in;
   logic [16:0] cal_measure_in;
   logic [16:0] tad_delay_out;
   logic [7:0] ramp_ctrl_out;
   ncs_word_t chan_a_phase_out;
   ncs_word_t chan_b_phase_out;
   logic irq_out;
   int err_total;
   int compares;
   logic [31:0] v, t, f, g, a1, b1;
   logic [31:0] fw [8];
   logic [31:0] ph [8];
   int n, ka, kb;
   int need [4] = '{4, 16, 64, 256};
   int lim [4] = '{85, 1100, 5200, 21580};

   ncs_regs #(.PRESETS(4), .REV_CODE(REV)) dut_u (
      .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sysref_in(sysref_in),
      .link_running_in(link_running_in), .chan_a_preset_in(chan_a_preset_in),
      .chan_b_preset_in(chan_b_preset_in), .cal_measure_in(cal_measure_in),
      .tad_delay_out(tad_delay_out), .ramp_ctrl_out(ramp_ctrl_out),
      .chan_a_phase_out(chan_a_phase_out), .chan_b_phase_out(chan_b_phase_out),
      .irq_out(irq_out));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] offset_step(input logic [15:0] p_new, input logic [15:0] p_old);
      return {16'(p_new - p_old), 16'h0000};
   endfunction : offset_step

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [9:0] a, input logic [31:0] d, input int nb = 1);
      for (int i = 0; i < nb; i++) begin
         @(posedge clk_sys_in);
         reg_addr_in <= a + 10'(i);
         reg_wdata_in <= d[8*i +: 8];
         reg_wr_in <= 1'b1;
      end
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [31:0] d, input int nb = 1);
      d = '0;
      for (int i = 0; i < nb; i++) begin
         @(posedge clk_sys_in);
         reg_addr_in <= a + 10'(i);
         reg_rd_in <= 1'b1;
         @(posedge clk_sys_in);
         reg_rd_in <= 1'b0;
         #1;
         d[8*i +: 8] = reg_rdata_out;
      end
   endtask : rd

   task automatic pulse();
      @(posedge clk_sys_in);
      sysref_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      sysref_in <= 1'b0;
      repeat (36) @(posedge clk_sys_in);
   endtask : pulse

   task automatic sample(output logic [31:0] pa, output logic [31:0] pb);
      @(posedge clk_sys_in);
      #1;
      pa = chan_a_phase_out;
      pb = chan_b_phase_out;
   endtask : sample

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------
   // clock and watchdog
   // ----------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   initial begin
      repeat (90000) @(posedge clk_sys_in);
      err_total++;
      $display("watchdog expired");
      conclude();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      reset_n_in = 1'b0;
      reg_addr_in = '0;
      reg_wdata_in = '0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      sysref_in = 1'b0;
      link_running_in = 1'b0;
      chan_a_preset_in = '0;
      chan_b_preset_in = '0;
      cal_measure_in = '0;
      void'($urandom(62));
      repeat (12) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      rd(`NCS_A_REV, v);
      check("revision", {27'h0, REV}, v);
      rd(`NCS_A_CFG, v);
      check("cfg reset", 32'h05, v);
      rd(`NCS_A_EN, v);
      check("enable reset", 32'h0, v);
      rd(`NCS_A_TAD0, v, 3);
      check("manual reset", 32'h0, v);
      rd(`NCS_A_NCO_LO, v, 4);
      check("freq reset", 32'hc0000000, v);
      check("delay out reset", 32'h0, {15'h0, tad_delay_out});
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         fw[k] = $urandom;
         ph[k] = $urandom;
         wr(`NCS_A_NCO_LO + 10'(k*4), fw[k], 4);
         wr(`NCS_A_NCO_PH + 10'(k*4), ph[k], 4);
      end
      for (int k = 0; k < 8; k++) begin
         rd(`NCS_A_NCO_LO + 10'(k*4), v, 4);
         check("freq word", fw[k], v);
         rd(`NCS_A_NCO_PH + 10'(k*4), v, 4);
         check("phase word", {16'h0, ph[k][15:0]}, v);
      end
      $display("test words done");
      for (int c = 0; c < 16; c++) begin
         wr(`NCS_A_CFG, ($urandom & 32'hf0) | 32'(c));
         rd(`NCS_A_CFG, v);
         check("cfg field", 32'(c), v);
      end
      wr(`NCS_A_EN, 32'hfe);
      rd(`NCS_A_EN, v);
      check("enable reserved", 32'h0, v);
      for (int a = 'h2b9; a <= 'h2bf; a++) begin
         wr(10'(a), $urandom);
         rd(10'(a), v);
         check("reserved byte", 32'h0, v);
      end
      wr(`NCS_A_REV, 32'hff);
      rd(`NCS_A_REV, v);
      check("revision ro", {27'h0, REV}, v);
      f = $urandom & 32'hff;
      wr(`NCS_A_RAMP, f);
      rd(`NCS_A_RAMP, v);
      check("ramp", f, v);
      check("ramp out", f, {24'h0, ramp_ctrl_out});
      t = $urandom & 32'hffffff;
      wr(`NCS_A_TAD0, t, 3);
      rd(`NCS_A_TAD0, v, 3);
      check("manual", t, v);
      check("delay manual", {15'h0, t[16:0]}, {15'h0, tad_delay_out});
      $display("test map done");
      for (int a = 0; a < 4; a++) begin
         cal_measure_in <= 17'($urandom);
         wr(`NCS_A_EN, 32'h0);
         wr(`NCS_A_CFG, 32'(a * 4 + 1));
         wr(`NCS_A_IRQ_CLR, 32'h7);
         wr(`NCS_A_EN, 32'h1);
         n = 0;
         v = '0;
         while (!v[17] && n < 300) begin
            pulse();
            n++;
            rd(`NCS_A_STAT0, v, 3);
         end
         check("average pulses", 1, {31'h0, n >= need[a] && n <= need[a] + 2});
         check("result", {14'h0, 1'b1, cal_measure_in}, v);
         wr(`NCS_A_TAD0, ~t, 3);
         check("delay cal", {15'h0, cal_measure_in}, {15'h0, tad_delay_out});
         wr(`NCS_A_TAD0, t, 3);
         rd(`NCS_A_IRQ_STAT, v);
         check("done irq", 32'h1, v & 32'h1);
         wr(`NCS_A_EN, 32'h1);
         rd(`NCS_A_STAT2, v);
         check("no restart", {30'h0, 1'b1, cal_measure_in[16]}, v);
         wr(`NCS_A_EN, 32'h0);
         rd(`NCS_A_STAT2, v);
         check("done cleared", 32'h0, v & 32'h2);
         check("delay back", {15'h0, t[16:0]}, {15'h0, tad_delay_out});
      end
      $display("test calibration done");
      wr(`NCS_A_IRQ_EN, 32'h2);
      rd(`NCS_A_IRQ_EN, v);
      check("irq enable", 32'h2, v);
      for (int h = 0; h < 4; h++) begin
         wr(`NCS_A_EN, 32'h0);
         wr(`NCS_A_CFG, 32'(h));
         wr(`NCS_A_IRQ_CLR, 32'h7);
         wr(`NCS_A_EN, 32'h1);
         repeat (lim[h] - 8) @(posedge clk_sys_in);
         rd(`NCS_A_IRQ_STAT, v);
         check("early fail", 32'h0, v & 32'h2);
         repeat (40) @(posedge clk_sys_in);
         rd(`NCS_A_IRQ_STAT, v);
         check("fail flag", 32'h2, v & 32'h2);
         check("fail irq", 32'h1, {31'h0, irq_out});
         rd(`NCS_A_STAT2, v);
         check("fail not done", 32'h0, v & 32'h2);
      end
      wr(`NCS_A_IRQ_EN, 32'h0);
      check("irq masked", 32'h0, {31'h0, irq_out});
      wr(`NCS_A_EN, 32'h0);
      wr(`NCS_A_IRQ_CLR, 32'h7);
      wr(`NCS_A_IRQ_EN, 32'h7);
      check("irq cleared", 32'h0, {31'h0, irq_out});
      $display("test failure done");
      chan_a_preset_in <= 2'($urandom);
      chan_b_preset_in <= 2'($urandom);
      @(posedge clk_sys_in);
      ka = int'(chan_a_preset_in);
      kb = 4 + int'(chan_b_preset_in);
      f = $urandom;
      g = $urandom;
      wr(`NCS_A_NCO_LO + 10'(ka*4), f, 4);
      wr(`NCS_A_NCO_LO + 10'(kb*4), g, 4);
      repeat (12) @(posedge clk_sys_in);
      sample(a1, b1);
      sample(v, t);
      check("accum a step", f, v - a1);
      check("accum b step", g, t - b1);
      wr(`NCS_A_NCO_LO + 10'(ka*4), 32'h0, 4);
      wr(`NCS_A_NCO_LO + 10'(kb*4), 32'h0, 4);
      repeat (12) @(posedge clk_sys_in);
      sample(a1, b1);
      f = $urandom & 32'hffff;
      g = $urandom & 32'hffff;
      wr(`NCS_A_NCO_PH + 10'(ka*4), f, 2);
      wr(`NCS_A_NCO_PH + 10'(kb*4), g, 2);
      repeat (12) @(posedge clk_sys_in);
      sample(v, t);
      check("phase a offset", offset_step(f[15:0], ph[ka][15:0]), v - a1);
      check("phase b offset", offset_step(g[15:0], ph[kb][15:0]), t - b1);
      link_running_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      wr(`NCS_A_IRQ_CLR, 32'h7);
      wr(`NCS_A_NCO_LO + 10'(ka*4), $urandom | 32'h1, 4);
      rd(`NCS_A_IRQ_STAT, v);
      check("rewrite while running", 32'h4, v & 32'h4);
      check("rewrite irq", 32'h1, {31'h0, irq_out});
      link_running_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      link_running_in <= 1'b1;
      repeat (20) @(posedge clk_sys_in);
      sample(a1, b1);
      link_running_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      link_running_in <= 1'b1;
      repeat (20) @(posedge clk_sys_in);
      sample(v, t);
      check("restart phase a", a1, v);
      link_running_in <= 1'b0;
      $display("test oscillator done");
      conclude();
   end
endmodule : tb_nco_word_and_sysref_cal_regs
